// file: rtl/lpsc_pkg.sv
// Purpose: constants for the low power sdram configuration register block
// Assumes: one 32-bit register reached over a plain strobe port
// Notes: offset of the register is local to this block
package lpsc_pkg;
	localparam logic [7:0] LPSC_CFG_OFFSET = 8'h00;
	localparam int LPSC_PARTIAL_LSB = 16;
	localparam int LPSC_ROW_LSB = 0;
	localparam logic [2:0] LPSC_PARTIAL_RESET = 3'h0;
	localparam logic [2:0] LPSC_ROW_RESET = 3'h0;
	// partial refresh codes
	localparam logic [2:0] LPSC_PR_FOUR = 3'h0;
	localparam logic [2:0] LPSC_PR_TWO = 3'h1;
	localparam logic [2:0] LPSC_PR_ONE = 3'h2;
	localparam logic [2:0] LPSC_PR_HALF = 3'h5;
	localparam logic [2:0] LPSC_PR_QUARTER = 3'h6;
	// extended mode register area encodings driven to the init sequencer
	localparam logic [2:0] LPSC_AREA_FOUR = 3'h0;
	localparam logic [2:0] LPSC_AREA_TWO = 3'h1;
	localparam logic [2:0] LPSC_AREA_ONE = 3'h2;
	localparam logic [2:0] LPSC_AREA_HALF = 3'h5;
	localparam logic [2:0] LPSC_AREA_QUARTER = 3'h6;
	// row bits: code 0..5 gives 9..14 bits
	localparam logic [3:0] LPSC_ROW_BASE = 4'h9;
	localparam logic [2:0] LPSC_ROW_MAX_CODE = 3'h5;
	localparam logic [3:0] LPSC_ROW_DEFAULT = 4'hd;
	// init sequencer states
	typedef enum logic [2:0] {
		LPSC_IDLE = 3'b001,
		LPSC_LOAD = 3'b010,
		LPSC_WAIT = 3'b100
	} lpsc_state_t;
endpackage : lpsc_pkg

// file: rtl/lpsc_cfg.sv
// Purpose: low power sdram second configuration register and init restart
// Assumes: single clock at 25 MHz, synchronous active-high reset
// Notes: init sequencer itself lives outside; this block requests and feeds it
module lpsc_cfg (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic bank_position_select_i,
	input wire logic mobile_mode_i,
	input wire logic init_done_i,
	output logic init_start_o,
	output logic init_busy_o,
	output logic emr_load_o,
	output logic [2:0] emr_area_o,
	output logic [3:0] row_bits_o,
	output logic row_override_o
);
	////////////////////////////////////////////////////////////////
	logic [2:0] partial_refresh_select;
	logic [2:0] row_bits_select;
	logic cfg_wr;
	lpsc_pkg::lpsc_state_t state;

	assign cfg_wr = wr_i && (addr_i == lpsc_pkg::LPSC_CFG_OFFSET);

	// map a partial refresh code to the area encoding; reserved codes fall back to full array
	function automatic logic [2:0] lpsc_area(input logic [2:0] code);
		unique case (code)
			lpsc_pkg::LPSC_PR_FOUR: lpsc_area = lpsc_pkg::LPSC_AREA_FOUR;
			lpsc_pkg::LPSC_PR_TWO: lpsc_area = lpsc_pkg::LPSC_AREA_TWO;
			lpsc_pkg::LPSC_PR_ONE: lpsc_area = lpsc_pkg::LPSC_AREA_ONE;
			lpsc_pkg::LPSC_PR_HALF: lpsc_area = lpsc_pkg::LPSC_AREA_HALF;
			lpsc_pkg::LPSC_PR_QUARTER: lpsc_area = lpsc_pkg::LPSC_AREA_QUARTER;
			default: lpsc_area = lpsc_pkg::LPSC_AREA_FOUR;
		endcase
	endfunction : lpsc_area

	////////////////////////////////////////////////////////////////
	// register storage; only field bits are kept so reserved bits cannot stick
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			partial_refresh_select <= lpsc_pkg::LPSC_PARTIAL_RESET;
			row_bits_select <= lpsc_pkg::LPSC_ROW_RESET;
		end
		else if (cfg_wr)
		begin
			partial_refresh_select <= wdata_i[lpsc_pkg::LPSC_PARTIAL_LSB +: 3];
			row_bits_select <= wdata_i[lpsc_pkg::LPSC_ROW_LSB +: 3];
		end
	end

	// read data one cycle after the strobe, zero otherwise and for unmapped offsets
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			rdata_o <= 32'h0;
		else if (rd_i && addr_i == lpsc_pkg::LPSC_CFG_OFFSET)
		begin
			rdata_o <= 32'h0; // reserved positions are never stored
			rdata_o[lpsc_pkg::LPSC_PARTIAL_LSB +: 3] <= partial_refresh_select;
			rdata_o[lpsc_pkg::LPSC_ROW_LSB +: 3] <= row_bits_select;
		end
		else
			rdata_o <= 32'h0;
	end

	////////////////////////////////////////////////////////////////
	// init restart: every write to the register retriggers, even mid-sequence
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			state <= lpsc_pkg::LPSC_IDLE;
		else if (cfg_wr)
			state <= lpsc_pkg::LPSC_LOAD;
		else
		begin
			unique case (state)
				lpsc_pkg::LPSC_IDLE: state <= lpsc_pkg::LPSC_IDLE;
				lpsc_pkg::LPSC_LOAD: state <= lpsc_pkg::LPSC_WAIT;
				lpsc_pkg::LPSC_WAIT: state <= init_done_i ? lpsc_pkg::LPSC_IDLE : lpsc_pkg::LPSC_WAIT;
				default: state <= lpsc_pkg::LPSC_IDLE;
			endcase
		end
	end

	// start pulse and extended mode load occur together, registered from the load state so they show in the cycle after it
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			init_start_o <= 1'b0;
			emr_load_o <= 1'b0;
			emr_area_o <= lpsc_pkg::LPSC_AREA_FOUR;
		end
		else
		begin
			init_start_o <= (state == lpsc_pkg::LPSC_LOAD);
			emr_load_o <= (state == lpsc_pkg::LPSC_LOAD);
			if (state == lpsc_pkg::LPSC_LOAD)
				emr_area_o <= lpsc_area(partial_refresh_select);
		end
	end

	assign init_busy_o = (state != lpsc_pkg::LPSC_IDLE);

	////////////////////////////////////////////////////////////////
	// row width applies only for mobile parts with bank position select set
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			row_bits_o <= lpsc_pkg::LPSC_ROW_DEFAULT;
			row_override_o <= 1'b0;
		end
		else
		begin
			row_override_o <= bank_position_select_i && mobile_mode_i;
			if (bank_position_select_i && mobile_mode_i && row_bits_select <= lpsc_pkg::LPSC_ROW_MAX_CODE)
				row_bits_o <= lpsc_pkg::LPSC_ROW_BASE + {1'b0, row_bits_select};
			else
				row_bits_o <= lpsc_pkg::LPSC_ROW_DEFAULT; // reserved codes ignored
		end
	end

	////////////////////////////////////////////////////////////////
	// a restart shows as a start pulse two edges after the write; a write mid-sequence starts over
	// writes to other offsets must leave the sequencer alone
	write_restart_a: assert property (@(posedge clk_i) disable iff (srst_i)
		cfg_wr |-> ##2 (init_start_o && emr_load_o))
		else $error("write did not restart init");
	busy_on_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
		cfg_wr |=> init_busy_o)
		else $error("write did not mark init busy");
	busy_release_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(state == lpsc_pkg::LPSC_WAIT && init_done_i && !cfg_wr) |=> !init_busy_o)
		else $error("init busy held after done");
	other_offset_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(wr_i && !cfg_wr && state == lpsc_pkg::LPSC_IDLE) |=> !init_busy_o)
		else $error("unmapped write restarted init");

	// area code reaches the output one edge after the load state and holds until the next load
	// reserved codes fall back to the full array so self refresh never drops data
	area_four_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(cfg_wr && wdata_i[18:16] == 3'h0) ##1 !cfg_wr |-> ##1 emr_area_o == 3'h0)
		else $error("four bank code not loaded");
	emr_two_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(cfg_wr && wdata_i[18:16] == 3'h1) ##1 !cfg_wr |-> ##1 emr_area_o == 3'h1)
		else $error("two bank code not loaded");
	area_one_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(cfg_wr && wdata_i[18:16] == 3'h2) ##1 !cfg_wr |-> ##1 emr_area_o == 3'h2)
		else $error("one bank code not loaded");
	emr_value_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(cfg_wr && wdata_i[18:16] == 3'h5) ##1 !cfg_wr |-> ##1 emr_area_o == 3'h5)
		else $error("half bank code not loaded");
	area_quarter_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(cfg_wr && wdata_i[18:16] == 3'h6) ##1 !cfg_wr |-> ##1 emr_area_o == 3'h6)
		else $error("quarter bank code not loaded");
	area_reserved_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(cfg_wr && wdata_i[18:16] inside {3'h3, 3'h4, 3'h7}) ##1 !cfg_wr |-> ##1 emr_area_o == 3'h0)
		else $error("reserved area code not mapped to full array");
	emr_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(state != lpsc_pkg::LPSC_LOAD) |=> $stable(emr_area_o))
		else $error("area code moved outside a load");

	// row width follows the field only for mobile parts with bank position select set
	// every other case parks the output at the default width
	row_width_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(bank_position_select_i && mobile_mode_i && row_bits_select == 3'h3) |=> row_bits_o == 4'hc)
		else $error("row width wrong");
	row_min_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(bank_position_select_i && mobile_mode_i && row_bits_select == 3'h0) |=> row_bits_o == 4'h9)
		else $error("smallest row width wrong");
	row_max_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(bank_position_select_i && mobile_mode_i && row_bits_select == 3'h5) |=> row_bits_o == 4'he)
		else $error("largest row width wrong");
	row_reserved_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(bank_position_select_i && mobile_mode_i && row_bits_select >= 3'h6) |=> row_bits_o == 4'hd)
		else $error("reserved row code not ignored");
	row_ignored_a: assert property (@(posedge clk_i) disable iff (srst_i)
		!bank_position_select_i |=> row_bits_o == 4'hd && !row_override_o)
		else $error("row field used without bank position");
	row_mobile_a: assert property (@(posedge clk_i) disable iff (srst_i)
		!mobile_mode_i |=> !row_override_o)
		else $error("row field used for plain sdram");
	override_on_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(bank_position_select_i && mobile_mode_i) |=> row_override_o)
		else $error("row field not applied for mobile part");

	// storage and read path; only the two fields exist, so reserved bits can never read back set
	// reset is checked without the disable so the cleared state itself is covered
	field_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
		!cfg_wr |=> $stable(partial_refresh_select) && $stable(row_bits_select))
		else $error("field changed without write");
	field_store_a: assert property (@(posedge clk_i) disable iff (srst_i)
		cfg_wr |=> row_bits_select == $past(wdata_i[2:0]))
		else $error("row field not stored");
	partial_store_a: assert property (@(posedge clk_i) disable iff (srst_i)
		cfg_wr |=> partial_refresh_select == $past(wdata_i[18:16]))
		else $error("partial refresh field not stored");
	read_back_a: assert property (@(posedge clk_i) disable iff (srst_i)
		cfg_wr ##1 (rd_i && addr_i == 8'h00 && !wr_i) |=> rdata_o == ($past(wdata_i, 2) & 32'h00070007))
		else $error("read back mismatch");
	reserved_zero_a: assert property (@(posedge clk_i) disable iff (srst_i)
		rdata_o[31:19] == 13'h0000 && rdata_o[15:3] == 13'h0000)
		else $error("reserved bits read as set");
	reset_clear_a: assert property (@(posedge clk_i)
		srst_i |=> partial_refresh_select == lpsc_pkg::LPSC_PARTIAL_RESET
			&& row_bits_select == lpsc_pkg::LPSC_ROW_RESET
			&& !init_busy_o && !init_start_o && !emr_load_o && rdata_o == 32'h0)
		else $error("reset left state behind");
endmodule : lpsc_cfg

// file: testbench/lpsc_init_model.sv
// Purpose: behavioural init sequencer and sdram far side
// Assumes: one start pulse launches one init run
// Notes: done is one cycle wide, after delay_i+1 cycles; a new start restarts
module lpsc_init_model (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic start_i,
	input wire logic load_i,
	input wire logic [2:0] area_i,
	input wire logic [3:0] delay_i,
	output logic done_o,
	output logic [2:0] emr_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] cnt;
	// count down the run; delay_i of zero answers on the next cycle
	always_ff @(posedge clk_i)
		if (srst_i)
			cnt <= 5'h00;
		else if (start_i)
			cnt <= {1'b0, delay_i} + 5'h01;
		else if (cnt != 5'h00)
			cnt <= cnt - 5'h01;
	assign done_o = (cnt == 5'h01);
	// extended mode register takes the area code during init
	always_ff @(posedge clk_i)
		if (srst_i)
			emr_o <= 3'h0;
		else if (load_i)
			emr_o <= area_i;
endmodule : lpsc_init_model

// file: testbench/tb_top.sv
// Purpose: self-checking bench for the low power sdram config register
// Assumes: strobe bus, read data in the cycle after rd_i
// Notes: seeded random fields and modes plus an unmapped access
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 0, srst_i = 1, wr_i = 0, rd_i = 0, bank_position_select_i = 0, mobile_mode_i = 0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0, rdata_o, q, w;
	logic row_on;
	logic [3:0] dly = 4'h2, row_bits_o;
	logic init_done_i, init_start_o, init_busy_o, emr_load_o, row_override_o;
	logic [2:0] emr_area_o, emr;
	int error_cnt = 0, num_checks = 0;
	initial forever #20 clk_i = ~clk_i;
	lpsc_cfg dut (.clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .bank_position_select_i,
		.mobile_mode_i, .init_done_i, .init_start_o, .init_busy_o, .emr_load_o, .emr_area_o, .row_bits_o,
		.row_override_o);
	lpsc_init_model mdl (.clk_i, .srst_i, .start_i(init_start_o), .load_i(emr_load_o), .area_i(emr_area_o),
		.delay_i(dly), .done_o(init_done_i), .emr_o(emr));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	// one-cycle strobes, released at the edge that takes them; read data taken at the edge that ends its cycle
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] dat, output logic [31:0] rq);
		@(posedge clk_i);
		wr_i <= wr;
		rd_i <= !wr;
		addr_i <= a;
		wdata_i <= dat;
		@(posedge clk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b0;
		@(posedge clk_i);
		rq = rdata_o;
		#1;
	endtask : bus
	// write and read with no gap: the read strobe rises at the edge that drops the write strobe
	task automatic wr_then_rd(input logic [31:0] dat, output logic [31:0] rq);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= 8'h00;
		wdata_i <= dat;
		@(posedge clk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(posedge clk_i);
		rq = rdata_o;
		#1;
	endtask : wr_then_rd
	// bounded wait for the init run; a hang ends the run as a failure
	task automatic wait_idle();
		for (int k = 0; k < 30 && init_busy_o !== 1'b0; k++)
			@(posedge clk_i);
		chk("busy end", init_busy_o, 0);
		if (init_busy_o !== 1'b0)
			tally_and_finish();
	endtask : wait_idle
	// reserved partial codes fall back to the full array
	function automatic logic [2:0] area_exp(input logic [2:0] c);
		return (c inside {3'h0, 3'h1, 3'h2, 3'h5, 3'h6}) ? c : 3'h0;
	endfunction : area_exp
	function automatic logic [3:0] row_exp(input logic [2:0] c, input logic on);
		return (on && c <= 3'h5) ? 4'h9 + {1'b0, c} : 4'hd;
	endfunction : row_exp
	initial
	begin
		void'($urandom(32'hf43a));
		repeat (10) @(posedge clk_i);
		srst_i <= 1'b0;
		bus(1'b0, 8'h00, 32'h0, q);
		chk("reset read", q, 0);
		chk("reset row", row_bits_o, 4'hd);
		chk("reset area", emr_area_o, 3'h0);
		$display("reset test done");
		// every code of both fields; even passes and the first eight keep the row field in force, odd ones from 8 up draw the modes
		for (int i = 0; i < 16; i++)
		begin
			w = 32'h0; // reserved positions always written as zero
			w[18:16] = i[2:0];
			w[2:0] = i[3:1];
			@(posedge clk_i);
			dly <= 4'($urandom % 8);
			bank_position_select_i <= !i[0] || (i < 8) || ($urandom % 2);
			mobile_mode_i <= !i[0] || (i < 8) || ($urandom % 2);
			bus(1'b1, 8'h00, w, q);
			row_on = bank_position_select_i && mobile_mode_i;
			chk("start", init_start_o, 1);
			chk("emr load", emr_load_o, 1);
			chk("area", emr_area_o, area_exp(w[18:16]));
			chk("row bits", row_bits_o, row_exp(w[2:0], row_on));
			chk("override", row_override_o, row_on);
			wait_idle();
			chk("model emr", emr, area_exp(w[18:16]));
			bus(1'b0, 8'h00, 32'h0, q);
			chk("readback", q, w & 32'h0007_0007);
		end
		$display("field sweep done");
		// random fields written and read back with no gap between the strobes
		w = 32'h0;
		w[18:16] = 3'($urandom % 8);
		w[2:0] = 3'($urandom % 8);
		wr_then_rd(w, q);
		chk("b2b read", q, w & 32'h0007_0007);
		wait_idle();
		chk("b2b emr", emr, area_exp(w[18:16]));
		$display("back to back test done");
		// unmapped offset: no restart, reads zero
		bus(1'b1, 8'h04, 32'h0002_0001, q);
		chk("no start", init_start_o, 0);
		chk("no busy", init_busy_o, 0);
		bus(1'b0, 8'h04, 32'h0, q);
		chk("unmapped", q, 0);
		bus(1'b0, 8'h00, 32'h0, q);
		chk("kept", q, w & 32'h0007_0007);
		$display("unmapped access test done");
		// reset in the middle of an init run drops the fields and the pending restart
		bus(1'b1, 8'h00, 32'h0005_0003, q);
		@(posedge clk_i);
		srst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		srst_i <= 1'b0;
		bus(1'b0, 8'h00, 32'h0, q);
		row_on = bank_position_select_i && mobile_mode_i;
		chk("reset again read", q, 0);
		chk("reset again busy", init_busy_o, 0);
		chk("reset again area", emr_area_o, 3'h0);
		chk("reset again row", row_bits_o, row_exp(3'h0, row_on));
		$display("mid-run reset test done");
		tally_and_finish();
	end
endmodule : tb_top
